// >>> testbench/emc_master_model.sv
// master-side partner model: presents frames to the codec and takes its answers
`default_nettype none
module emc_master_model (
  input wire logic mclk,
  output emc_pkg::emc_rx_s rx,
  input wire logic rx_ready,
  input wire emc_pkg::emc_msg_s tx_msg,
  input wire logic tx_valid,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  import emc_pkg::*;
  initial begin
    rx = '0;
    tx_ready = 1'b0;
  end
  // waits a bounded time for an answer, then may stall before taking it
  task automatic take(input int stall, output logic got, output emc_msg_s a);
    got = 1'b0;
    a = '0;
    for (int i = 0; i < 6 && !got; i++) begin
      @(posedge mclk);
      got = (tx_valid === 1'b1);
      a = tx_msg;
    end
    if (got) begin
      repeat (stall) @(posedge mclk);
      tx_ready <= 1'b1;
      @(posedge mclk);
      tx_ready <= 1'b0;
    end
  endtask
  task automatic xfer(input emc_msg_s m, input logic [7:0] h, input logic [9:0] n,
      input int stall, output logic acc, output logic got, output emc_msg_s a);
    acc = 1'b0;
    rx <= '{1'b1, h, n, m};
    for (int i = 0; i < 20 && !acc; i++) begin
      @(posedge mclk);
      acc = (rx_ready === 1'b1);
    end
    rx.valid <= 1'b0;
    // released lines carry the inverse so a stale message is never mistaken for a new one
    rx.msg <= ~m;
    take(stall, got, a);
  endtask
endmodule
`default_nettype wire

// >>> testbench/emc_remote_codec_bench.sv
// self-checking bench of the remote-side eoc codec
`default_nettype none
`include "emc_defs.svh"
module emc_remote_codec_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import emc_pkg::*;
  logic mclk, resetn, rx_ready, tx_valid, tx_ready, corrupt_checks, peer_corrupt;
  logic self_check_cmd, refresh_test_params_cmd, bus_wr, bus_rd;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic [31:0] scp = 32'h0;
  logic [31:0] rtp = 32'h0;
  emc_rx_s rx;
  emc_msg_s tx_msg;
  emc_proto_e proto_state;
  int errors, comparisons;
  localparam logic [7:0] HINT = `EMC_HDLC_INT;
  localparam logic [7:0] STAT = `EMC_OFS_STATUS;
  localparam emc_msg_s NO_COMPLY = '{2'h0, 1'b1, 1'b1, 1'b1, `EMC_OP_CANNOT, 3'h0};

  emc_remote_codec dut_u (.mclk(mclk), .resetn(resetn), .rx(rx), .rx_ready(rx_ready),
    .tx_msg(tx_msg), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .corrupt_checks(corrupt_checks), .peer_corrupt(peer_corrupt),
    .self_check_cmd(self_check_cmd), .refresh_test_params_cmd(refresh_test_params_cmd),
    .proto_state(proto_state), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  emc_master_model partner_u (.mclk(mclk), .rx(rx), .rx_ready(rx_ready),
    .tx_msg(tx_msg), .tx_valid(tx_valid), .tx_ready(tx_ready));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // pulse counters, so a pulse longer than one cycle shows as a miscount
  always @(posedge mclk) begin
    scp <= scp + {31'h0, self_check_cmd === 1'b1};
    rtp <= rtp + {31'h0, refresh_test_params_cmd === 1'b1};
  end

  task automatic close_out;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the extra edge keeps back-to-back calls from assigning a strobe twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    @(posedge mclk);
    chk(bus_rdata & mask, exp);
  endtask
  function automatic emc_msg_s cmd(logic is_op, logic par, logic [7:0] info);
    return '{2'h0, is_op, par, 1'b1, info, 3'h0};
  endfunction
  task automatic send(input emc_msg_s m, input logic [7:0] h, input logic [9:0] n,
      input logic eg, input emc_msg_s ea);
    logic acc, got;
    emc_msg_s a;
    partner_u.xfer(m, h, n, 0, acc, got, a);
    if (acc !== 1'b1) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, acc, 1'b1);
      close_out();
    end
    chk({31'h0, got}, {31'h0, eg});
    if (eg) begin
      chk({16'h0, a}, {16'h0, ea});
    end
  endtask

  task automatic t_reset;
    rd(`EMC_OFS_CTRL, 32'h1, 32'h1);
    rd(STAT, 32'h7FFF, 32'h0);
    rd(8'h44, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, tx_valid}, 32'h0);
  endtask
  task automatic t_cmds;
    logic [7:0] op[10] = '{8'h07, 8'h0B, 8'h01, 8'h13, 8'h02, 8'h08, 8'h0D, 8'h07, 8'h0B,
      8'hF0};
    logic [1:0] lat[10] = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
    for (int i = 0; i < 10; i++) begin
      send(cmd(1'b1, 1'b1, op[i]), HINT, 10'h2, 1'b1, cmd(1'b1, 1'b1, op[i]));
      chk({30'h0, corrupt_checks, peer_corrupt}, {30'h0, lat[i]});
    end
    chk(scp, 32'h1);
    chk(rtp, 32'h1);
  endtask
  task automatic t_refuse;
    emc_msg_s m[8] = '{cmd(1'b1, 1'b1, 8'h04), cmd(1'b1, 1'b1, 8'h19), cmd(1'b1, 1'b0, 8'h01),
      cmd(1'b1, 1'b1, 8'h10), cmd(1'b0, 1'b1, 8'h5A), cmd(1'b1, 1'b1, 8'h0E),
      cmd(1'b1, 1'b1, 8'h20), cmd(1'b1, 1'b1, 8'h61)};
    for (int i = 0; i < 8; i++) begin
      send(m[i], HINT, 10'h2, 1'b1, NO_COMPLY);
    end
  endtask
  task automatic t_discard;
    logic [10:0] t[6] = '{{2'h1, 1'b1, 8'h01}, {2'h2, 1'b1, 8'h01}, {2'h3, 1'b1, 8'h01},
      {2'h0, 1'b0, 8'h01}, {2'h0, 1'b1, 8'h80}, {2'h0, 1'b1, 8'h8F}};
    emc_msg_s d;
    for (int i = 0; i < 6; i++) begin
      d = '{t[i][10:9], 1'b1, 1'b1, t[i][8], t[i][7:0], 3'h0};
      send(d, HINT, 10'h2, 1'b0, '0);
    end
    send(cmd(1'b1, 1'b1, 8'h01), 8'h22, 10'h2, 1'b0, '0);
    send(cmd(1'b1, 1'b1, 8'h01), HINT, 10'h1, 1'b0, '0);
    rd(STAT, 32'h7FE0, 32'h100);
    send(cmd(1'b1, 1'b1, 8'h01), `EMC_HDLC_EXT, 10'h1FE, 1'b0, '0);
    rd(STAT, 32'h10, 32'h0);
    send(cmd(1'b1, 1'b1, 8'h01), `EMC_HDLC_EXT, 10'h1FF, 1'b0, '0);
    rd(STAT, 32'h10, 32'h10);
    wr(STAT, 32'h10);
    rd(STAT, 32'h7FF0, 32'h0);
  endtask
  task automatic t_write;
    send(cmd(1'b1, 1'b1, 8'h20), HINT, 10'h2, 1'b1, NO_COMPLY);
    send(cmd(1'b1, 1'b1, 8'h2A), HINT, 10'h2, 1'b1, cmd(1'b1, 1'b1, 8'h2A));
    chk({30'h0, proto_state}, 32'h1);
    send(cmd(1'b0, 1'b1, 8'hA5), HINT, 10'h2, 1'b1, cmd(1'b0, 1'b1, 8'hA5));
    send(cmd(1'b0, 1'b0, 8'h3C), HINT, 10'h2, 1'b1, cmd(1'b0, 1'b0, 8'h3C));
    // a byte beyond the register length is refused with end of data
    send(cmd(1'b0, 1'b1, 8'h99), HINT, 10'h2, 1'b1, cmd(1'b1, 1'b1, 8'h0E));
    send(cmd(1'b1, 1'b1, 8'h0E), HINT, 10'h2, 1'b1, cmd(1'b1, 1'b1, 8'h0E));
    chk({30'h0, proto_state}, 32'h0);
    rd(8'hA8, 32'hFF, 32'hA5);
    rd(8'hAC, 32'hFF, 32'h3C);
  endtask
  task automatic t_read;
    wr(8'hB0, 32'h81);
    wr(8'hB4, 32'h7E);
    send(cmd(1'b1, 1'b1, 8'h4C), HINT, 10'h2, 1'b1, cmd(1'b1, 1'b1, 8'h4C));
    chk({30'h0, proto_state}, 32'h3);
    send(cmd(1'b1, 1'b1, 8'h10), HINT, 10'h2, 1'b1, cmd(1'b0, 1'b1, 8'h81));
    send(cmd(1'b1, 1'b0, 8'h10), HINT, 10'h2, 1'b1, cmd(1'b0, 1'b0, 8'h7E));
    send(cmd(1'b1, 1'b1, 8'h10), HINT, 10'h2, 1'b1, cmd(1'b1, 1'b1, 8'h0E));
    chk({30'h0, proto_state}, 32'h0);
    send(cmd(1'b1, 1'b1, 8'h14), HINT, 10'h2, 1'b1, cmd(1'b1, 1'b1, 8'h0E));
    rd(`EMC_OFS_LAST_RX, 32'hFFFF, {16'h0, cmd(1'b1, 1'b1, 8'h14)});
  endtask
  task automatic t_auto;
    logic acc, got;
    emc_msg_s a;
    wr(`EMC_OFS_AUTO, 32'h13);
    partner_u.take(3, got, a);
    chk({31'h0, got}, 32'h1);
    chk({16'h0, a}, {16'h0, 2'h3, 1'b1, 1'b1, 1'b0, 8'h13, 3'h0});
    rd(`EMC_OFS_AUTO, 32'h100, 32'h0);
    wr(`EMC_OFS_CTRL, 32'h0);
    partner_u.xfer(cmd(1'b1, 1'b1, 8'h01), HINT, 10'h2, 0, acc, got, a);
    chk({30'h0, acc, got}, 32'h0);
    wr(`EMC_OFS_CTRL, 32'h1);
    send(cmd(1'b1, 1'b1, 8'h01), HINT, 10'h2, 1'b1, cmd(1'b1, 1'b1, 8'h01));
  endtask

  initial begin
    resetn = 1'b0;
    bus_addr = 8'h0;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    errors = 0;
    comparisons = 0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_cmds();
    t_refuse();
    t_discard();
    t_write();
    t_read();
    t_auto();
    close_out();
  end
endmodule
`default_nettype wire

// >>> verilog/emc_defs.svh
// constants of the remote-side eoc message codec
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH
`define EMC_ADDR_MASTER 2'h3
`define EMC_ADDR_REMOTE 2'h0
`define EMC_HDLC_EXT 8'hFF
`define EMC_HDLC_INT 8'h11
`define EMC_EXT_MAX 10'h1FE
`define EMC_INT_MIN 10'h002
`define EMC_OP_HOLD 8'h01
`define EMC_OP_RET_NORMAL 8'hF0
`define EMC_OP_SELF_CHECK 8'h02
`define EMC_OP_CANNOT 8'h04
`define EMC_OP_ASK_CORRUPT 8'h07
`define EMC_OP_ASK_STOP 8'h08
`define EMC_OP_ANN_CORRUPT 8'h0B
`define EMC_OP_ANN_STOP 8'h0D
`define EMC_OP_END_XFER 8'h0E
`define EMC_OP_NEXT 8'h10
`define EMC_OP_REFRESH 8'h13
`define EMC_OP_REPEAT 8'h14
`define EMC_RD_DELTA 8'h20
`define EMC_WR_OPS {8'h3E, 8'h3D, 8'h3B, 8'h38, 8'h37, 8'h34, 8'h32, 8'h31, \
  8'h2F, 8'h2C, 8'h2A, 8'h29, 8'h26, 8'h25, 8'h23, 8'h20}
`define EMC_VENDOR_OPS 8'h19, 8'h1A, 8'h1C, 8'h1F
`define EMC_RSV_OPS 8'h15, 8'h16, 8'h80, 8'h83, 8'h85, 8'h86, 8'h89, 8'h8A, 8'h8C, 8'h8F
`define EMC_OFS_CTRL 8'h00
`define EMC_OFS_STATUS 8'h04
`define EMC_OFS_AUTO 8'h08
`define EMC_OFS_LAST_RX 8'h0C
`define EMC_OFS_MEM 8'h80
`define EMC_CTRL_EN 0
`define EMC_CTRL_RST 1'b1
`define EMC_STAT_OVSZ 4
`endif

// >>> verilog/emc_pkg.sv
// types shared by the eoc message codec
`default_nettype none
package emc_pkg;
  typedef enum logic [1:0] {
    EMC_IDLE = 2'h0,
    EMC_WRITE = 2'h1,
    EMC_READ = 2'h3
  } emc_proto_e;
  typedef struct packed {
    logic [1:0] addr;
    logic is_op;
    logic par;
    logic is_cmd;
    logic [7:0] info;
    logic [2:0] rsv;
  } emc_msg_s;
  typedef struct packed {
    logic valid;
    logic [7:0] hdlc;
    logic [9:0] octets;
    emc_msg_s msg;
  } emc_rx_s;
endpackage
`default_nettype wire

// >>> verilog/emc_remote_codec.sv
// remote-side eoc codec: parse, echo, latch, register transfer, autonomous send
`include "emc_defs.svh"
`default_nettype none
module emc_remote_codec #(
  parameter int REG_BYTES = 2,
  parameter logic [15:0] WR_MASK = 16'h0060
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire emc_pkg::emc_rx_s rx,
  output logic rx_ready,
  output emc_pkg::emc_msg_s tx_msg,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic corrupt_checks,
  output logic peer_corrupt,
  output logic self_check_cmd,
  output logic refresh_test_params_cmd,
  output emc_pkg::emc_proto_e proto_state,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata
);
  import emc_pkg::*;

  localparam int NB = 16 * REG_BYTES;
  localparam int AW = $clog2(NB);
  localparam int CW = $clog2(REG_BYTES + 1);
  localparam logic [CW-1:0] LEN = CW'(REG_BYTES);
  // opcodes chosen with odd weight, so one flipped bit never turns into another code
  localparam logic [15:0][7:0] WR_OPS = `EMC_WR_OPS;

  typedef struct packed {
    logic en;
    emc_proto_e proto;
    logic [3:0] idx;
    logic [CW-1:0] cnt;
    logic par;
    logic ask_cor;
    logic ann_cor;
    logic ovsz;
    logic [9:0] drops;
    logic tx_v;
    emc_msg_s tx;
    emc_msg_s last_tx;
    emc_msg_s last_rx;
    logic auto_v;
    logic [7:0] auto_op;
    logic [31:0] rdata;
    logic tpu;
    logic self;
    logic [NB-1:0][7:0] mem;
  } emc_st_s;

  function automatic emc_msg_s mk(input logic [1:0] a, input logic op,
      input logic par, input logic cmd, input logic [7:0] info);
    emc_msg_s r;
    r.addr = a;
    r.is_op = op;
    r.par = par;
    r.is_cmd = cmd;
    r.info = info;
    r.rsv = 3'h0;
    return r;
  endfunction

  function automatic logic op_reserved(input logic [7:0] op);
    logic r;
    r = 1'b0;
    case (op)
      `EMC_RSV_OPS: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // hit flag in bit 4, register number below it
  function automatic logic [4:0] reg_of(input logic [7:0] op);
    logic [4:0] r;
    r = 5'h0;
    for (int i = 0; i < 16; i++) begin
      if (WR_OPS[i] == op) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  emc_st_s s;
  emc_st_s n;
  emc_msg_s m;
  emc_msg_s rep;
  emc_msg_s cant;
  emc_msg_s endx;
  logic acc;
  logic send;
  logic mhit;
  logic [4:0] wh;
  logic [4:0] rh;
  logic [AW-1:0] bi;
  logic [AW-1:0] ai;
  logic [7:0] moff;

  // one message in flight: the master waits for each answer anyway
  assign rx_ready = s.en && !s.tx_v;
  assign acc = rx.valid && rx_ready;
  assign m = rx.msg;
  assign wh = reg_of(m.info);
  assign rh = reg_of(8'(m.info - `EMC_RD_DELTA));
  assign bi = AW'(s.idx * REG_BYTES + s.cnt);
  assign moff = 8'(bus_addr - `EMC_OFS_MEM);
  assign ai = AW'(moff >> 2);
  assign mhit = bus_addr >= `EMC_OFS_MEM && (moff >> 2) < NB && moff[1:0] == 2'h0;
  assign cant = mk(`EMC_ADDR_REMOTE, 1'b1, 1'b1, 1'b1, `EMC_OP_CANNOT);
  assign endx = mk(`EMC_ADDR_REMOTE, 1'b1, 1'b1, 1'b1, `EMC_OP_END_XFER);

  always_comb begin
    n = s;
    send = 1'b0;
    rep = s.last_tx;
    n.tpu = 1'b0;
    n.self = 1'b0;
    n.rdata = 32'h0;
    if (s.tx_v && tx_ready) n.tx_v = 1'b0;
    if (bus_rd) begin
      if (bus_addr == `EMC_OFS_CTRL) begin
        n.rdata = {31'h0, s.en};
      end else if (bus_addr == `EMC_OFS_STATUS) begin
        n.rdata = {17'h0, s.drops, s.ovsz, s.ann_cor, s.ask_cor, s.proto};
      end else if (bus_addr == `EMC_OFS_AUTO) begin
        n.rdata = {23'h0, s.auto_v, s.auto_op};
      end else if (bus_addr == `EMC_OFS_LAST_RX) begin
        n.rdata = {16'h0, s.last_rx};
      end else if (mhit) begin
        n.rdata = {24'h0, s.mem[ai]};
      end
    end
    // software writes come first so that hardware events in the same cycle win, except that a write to the auto register keeps auto_v set
    if (bus_wr) begin
      if (bus_addr == `EMC_OFS_CTRL) begin
        n.en = bus_wdata[`EMC_CTRL_EN];
      end else if (bus_addr == `EMC_OFS_STATUS) begin
        if (bus_wdata[`EMC_STAT_OVSZ]) begin
          n.ovsz = 1'b0;
          n.drops = 10'h0;
        end
      end else if (bus_addr == `EMC_OFS_AUTO) begin
        n.auto_op = bus_wdata[7:0];
        n.auto_v = 1'b1;
      end else if (mhit) begin
        n.mem[ai] = bus_wdata[7:0];
      end
    end
    if (acc) begin
      if (rx.hdlc == `EMC_HDLC_EXT) begin
        // external traffic is passed on elsewhere; only its size is policed here
        if (rx.octets > `EMC_EXT_MAX) n.ovsz = 1'b1;
      end else if (rx.hdlc != `EMC_HDLC_INT || rx.octets < `EMC_INT_MIN
          || m.addr != `EMC_ADDR_REMOTE
          || !m.is_cmd
          || (m.is_op && op_reserved(m.info))) begin
        if (s.drops != 10'h3FF) n.drops = 10'(s.drops + 10'h1);
      end else begin
        n.last_rx = m;
        send = 1'b1;
        rep = m;
        if (!m.is_op) begin
          if (s.proto == EMC_WRITE && m.par == s.par) begin
            if (s.cnt < LEN) begin
              n.mem[bi] = m.info;
              n.cnt = CW'(s.cnt + 1'b1);
              n.par = !s.par;
            end else begin
              rep = endx;
            end
          end else begin
            rep = cant;
          end
        end else if (m.info != `EMC_OP_NEXT && !m.par) begin
          rep = cant;
        end else begin
          case (m.info)
            `EMC_OP_HOLD: begin
              rep = m;
            end
            `EMC_OP_RET_NORMAL: begin
              n.ask_cor = 1'b0;
              n.ann_cor = 1'b0;
              n.proto = EMC_IDLE;
              n.cnt = '0;
            end
            `EMC_OP_SELF_CHECK: begin
              n.self = 1'b1;
            end
            `EMC_OP_ASK_CORRUPT: begin
              n.ask_cor = 1'b1;
            end
            `EMC_OP_ASK_STOP: begin
              n.ask_cor = 1'b0;
            end
            `EMC_OP_ANN_CORRUPT: begin
              n.ann_cor = 1'b1;
            end
            `EMC_OP_ANN_STOP: begin
              n.ann_cor = 1'b0;
            end
            `EMC_OP_REFRESH: begin
              n.tpu = 1'b1;
            end
            `EMC_OP_REPEAT: begin
              rep = s.last_tx;
            end
            `EMC_OP_END_XFER: begin
              if (s.proto != EMC_IDLE) n.proto = EMC_IDLE;
              else rep = cant;
            end
            `EMC_OP_NEXT: begin
              if (s.proto == EMC_READ && m.par == s.par) begin
                if (s.cnt < LEN) begin
                  rep = mk(`EMC_ADDR_REMOTE, 1'b0, s.par, 1'b1, s.mem[bi]);
                  n.cnt = CW'(s.cnt + 1'b1);
                  n.par = !s.par;
                end else begin
                  rep = endx;
                  n.proto = EMC_IDLE;
                end
              end else begin
                rep = cant;
              end
            end
            `EMC_VENDOR_OPS: begin
              rep = cant;
            end
            default: begin
              if (wh[4] && WR_MASK[wh[3:0]]) begin
                n.proto = EMC_WRITE;
                n.idx = wh[3:0];
                n.cnt = '0;
                n.par = 1'b1;
              end else if (rh[4]) begin
                n.proto = EMC_READ;
                n.idx = rh[3:0];
                n.cnt = '0;
                n.par = 1'b1;
              end else begin
                // covers a received cannot-comply, an upstream-only code
                rep = cant;
              end
            end
          endcase
        end
      end
    end else if (!rx.valid && s.en && !s.tx_v && s.auto_v) begin
      // autonomous slot only when the master is silent, so it never poses as a reply
      send = 1'b1;
      rep = mk(`EMC_ADDR_MASTER, 1'b1, 1'b1, 1'b0, s.auto_op);
      if (!(bus_wr && bus_addr == `EMC_OFS_AUTO)) n.auto_v = 1'b0;
    end
    if (send) begin
      n.tx = rep;
      n.tx_v = 1'b1;
      n.last_tx = rep;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s <= '0;
      s.en <= `EMC_CTRL_RST;
    end else begin
      s <= n;
    end
  end

  assign tx_msg = s.tx;
  assign tx_valid = s.tx_v;
  assign corrupt_checks = s.ask_cor;
  assign peer_corrupt = s.ann_cor;
  assign self_check_cmd = s.self;
  assign refresh_test_params_cmd = s.tpu;
  assign proto_state = s.proto;
  assign bus_rdata = s.rdata;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence int_ok_s;
    acc && rx.hdlc == `EMC_HDLC_INT && rx.octets >= `EMC_INT_MIN
      && m.addr == `EMC_ADDR_REMOTE && m.is_cmd;
  endsequence

  sequence op_in_s;
    int_ok_s ##0 (m.is_op && m.par && !op_reserved(m.info));
  endsequence

  echo_copy_a: assert property (
    op_in_s ##0 (m.info == `EMC_OP_HOLD) |=> tx_valid && tx_msg == $past(rx.msg))
    else $error("hold command not echoed verbatim");

  next_answer_a: assert property (
    int_ok_s ##0 (m.is_op && m.info == `EMC_OP_NEXT) |=> tx_valid && tx_msg != $past(rx.msg))
    else $error("next byte was echoed");

  ret_clear_a: assert property (
    op_in_s ##0 (m.info == `EMC_OP_RET_NORMAL)
      |=> !corrupt_checks && !peer_corrupt && proto_state == EMC_IDLE)
    else $error("return to normal left state behind");

  ask_latch_a: assert property (
    op_in_s ##0 (m.info == `EMC_OP_ASK_CORRUPT) |=> corrupt_checks [*2])
    else $error("corrupt request did not latch");

  latch_keep_a: assert property (
    corrupt_checks && !(acc && m.is_op
      && (m.info == `EMC_OP_RET_NORMAL || m.info == `EMC_OP_ASK_STOP)) |=> corrupt_checks)
    else $error("corrupt latch released without command");

  rsv_bits_a: assert property (
    tx_valid |-> tx_msg.rsv == 3'h0)
    else $error("reserved bits not zero");

  reply_addr_a: assert property (
    tx_valid && tx_msg.is_cmd |-> tx_msg.addr == `EMC_ADDR_REMOTE)
    else $error("reply with wrong address");

  auto_form_a: assert property (
    tx_valid && !tx_msg.is_cmd |-> tx_msg.addr == `EMC_ADDR_MASTER && tx_msg.is_op)
    else $error("bad autonomous message");

  op_parity_a: assert property (
    tx_valid && tx_msg.is_op |-> tx_msg.par)
    else $error("opcode sent with parity zero");

  short_drop_a: assert property (
    acc && rx.hdlc == `EMC_HDLC_INT && rx.octets < `EMC_INT_MIN |=> !tx_valid)
    else $error("short frame answered");

  resv_drop_a: assert property (
    acc && (m.addr == 2'h1 || m.addr == 2'h2 || (m.is_op && op_reserved(m.info)))
      |=> !tx_valid)
    else $error("reserved message answered");

  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_msg))
    else $error("answer dropped before taken");
endmodule
`default_nettype wire
